// file: src/tbr_timebase.sv
// Timebase generation and reference clock routing for the acquisition device.
// Assumes one 250 MHz clock; timebases leave as one-cycle enables, pins pass four flops.
//
// How it works
// - A 100 MHz master enable comes from oscillator or from the tracked reference.
// - The 20 MHz enable is the master divided by five, phase related.
// - The 100 kHz enable is the 20 MHz enable divided by 200.
// - Each counter picks 20 MHz or 100 kHz; both also go to analog timing.
// - Reference select covers sync bus, terminals, backplane clock, star, star A, B.
// - With the loop on, the selected reference realigns the master enable phase.
// - Loop on/off and source changes apply only while no task runs.
// - A 10 MHz reference is divided from the oscillator, apart from the loop.
// - The 10 MHz reference may drive any sync-bus line or function terminal.
// - Initiator exports 10 MHz on a shared line; all, itself too, select that line.
// - The backplane 100 MHz clock can be selected as reference.
// - The star trigger line can be selected as reference.
// - The USB variant neither drives nor selects sync-bus lines.
`timescale 1ns/1ps
module tbr_timebase
  import tbr_pkg::*;
#(
  parameter bit USB_VARIANT = 1'b0,  // Build without shared sync-bus support.
  parameter int NUM_CTR     = 4      // Number of general-purpose counters.
) (
  input  wire logic                 clk_sys_i,       // System clock, 250 MHz.
  input  wire logic                 arst_n_i,        // Asynchronous reset, active low.
  input  wire logic                 pll_en_i,        // Requested loop enable.
  input  wire tbr_pkg::tbr_sel_type ref_sel_i,       // Requested reference source.
  input  wire logic                 tasks_busy_i,    // Any subsystem task running.
  input  wire logic [NUM_CTR-1:0]   ctr_tb_sel_i,    // Per counter: 1 picks 100 kHz.
  input  wire logic [7:0]           sync_bus_i,      // Shared sync-bus pin levels.
  input  wire logic [15:0]          pft_i,           // Function terminal pin levels.
  input  wire logic                 bp100_i,         // Backplane 100 MHz clock.
  input  wire logic                 star_i,          // Star trigger line.
  input  wire logic                 dstar_a_i,       // Differential star A.
  input  wire logic                 dstar_b_i,       // Differential star B.
  input  wire logic [7:0]           exp_sync_en_i,   // Export 10 MHz on sync line.
  input  wire logic [15:0]          exp_pft_en_i,    // Export 10 MHz on terminal.
  output logic                      tick_100m_o,     // Master enable.
  output logic                      tick_20m_o,      // 20 MHz enable.
  output logic                      tick_100k_o,     // 100 kHz enable.
  output logic [NUM_CTR-1:0]        ctr_tick_o,      // Counter source enables.
  output logic                      ref10_o,         // 10 MHz square wave.
  output logic [7:0]                sync_bus_o,      // Sync-bus drive level.
  output logic [7:0]                sync_bus_oe_n_o, // Sync-bus enable, low drives.
  output logic [15:0]               pft_o,           // Terminal drive level.
  output logic [15:0]               pft_oe_n_o,      // Terminal enable, low drives.
  output logic                      pll_on_o,        // Loop path active.
  output tbr_pkg::tbr_sel_type      ref_sel_o,       // Applied reference source.
  output logic                      cfg_pending_o,   // Request held off by busy.
  output logic                      pll_locked_o     // Reference edges arriving.
);
  import tbr_pkg::*;

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  logic [NUM_SRC-1:0] ext_raw;
  logic [NUM_SRC-1:0] s1_r, s2_r, s3_r, sq_r;
  logic [31:0]        ext_f;

  assign ext_raw = {dstar_b_i, dstar_a_i, star_i, bp100_i, pft_i, sync_bus_i};

  // A level counts only once the second and third stages agree; the first stage feeds the second alone.
  for (genvar g = 0; g < NUM_SRC; g++) begin : g_sync
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        s1_r[g] <= 1'b0;
        s2_r[g] <= 1'b0;
        s3_r[g] <= 1'b0;
        sq_r[g] <= 1'b0;
      end else begin
        s1_r[g] <= ext_raw[g];
        s2_r[g] <= s1_r[g];
        s3_r[g] <= s2_r[g];
        if (s2_r[g] == s3_r[g]) begin
          sq_r[g] <= s3_r[g];
        end
      end
    end
  end
  assign ext_f = {{(32 - NUM_SRC){1'b0}}, sq_r};

  // ---------------------------------------------------------------------------
  // Configuration
  // ---------------------------------------------------------------------------
  logic        pll_on_r;
  tbr_sel_type ref_sel_r;
  logic        sel_ok;
  logic        cfg_diff;
  logic        pending_r;

  // Sync-bus codes are refused on the USB build; codes past the table never apply.
  assign sel_ok   = (ref_sel_i < SEL_LIMIT) && !(USB_VARIANT && ref_sel_i < SEL_PFT_BASE);
  assign cfg_diff = (pll_en_i != pll_on_r) || (sel_ok && ref_sel_i != ref_sel_r);

  // Switching the loop disturbs every subsystem's clock, so changes wait for an idle device.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pll_on_r  <= 1'b0;
      // The USB build has no sync bus, so its idle code must already be a terminal.
      ref_sel_r <= USB_VARIANT ? SEL_PFT_BASE : SEL_SYNC_BASE;
      pending_r <= 1'b0;
    end else begin
      pending_r <= cfg_diff && tasks_busy_i;
      if (!tasks_busy_i) begin
        pll_on_r <= pll_en_i;
        if (sel_ok) begin
          ref_sel_r <= ref_sel_i;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Reference edge and lock tracking
  // ---------------------------------------------------------------------------
  logic       ref_lvl_r;
  logic       ref_rise;
  logic [9:0] gap_r;
  logic [2:0] edges_r;
  logic       locked_r;

  assign ref_rise = ext_f[ref_sel_r] && !ref_lvl_r;

  // A reference pulled away mid-task shows as lost lock; the timebases fall back to free-running phase.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ref_lvl_r <= 1'b0;
      gap_r     <= 10'h000;
      edges_r   <= 3'h0;
      locked_r  <= 1'b0;
    end else begin
      ref_lvl_r <= ext_f[ref_sel_r];
      if (!pll_on_r || gap_r == LOCK_TO_LAST) begin
        gap_r    <= 10'h000;
        edges_r  <= 3'h0;
        locked_r <= 1'b0;
      end else if (ref_rise) begin
        gap_r <= 10'h000;
        if (edges_r == LOCK_EDGES) begin
          locked_r <= 1'b1;
        end else begin
          edges_r <= edges_r + 3'h1;
        end
      end else begin
        gap_r <= gap_r + 10'h001;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Master, 10 MHz and divided timebases
  // ---------------------------------------------------------------------------
  tbr_tick_if m_if ();
  tbr_tick_if r_if ();

  // Backplane 100 MHz cannot be resolved at this sample rate; only its sampled edges realign.
  assign m_if.phase_rst = pll_on_r && ref_rise;
  assign r_if.phase_rst = 1'b0;

  tbr_phase_acc #(.INC(MASTER_INC), .MOD(ACC_MOD)) u_master (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .tk        (m_if.gen)
  );

  tbr_phase_acc #(.INC(REF10_INC), .MOD(ACC_MOD)) u_ref10 (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .tk        (r_if.gen)
  );

  logic [2:0] div20_r;
  logic [7:0] div100k_r;

  // The 100 kHz count advances on the registered 20 MHz enable so both stay phase related.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div20_r     <= 3'h0;
      div100k_r   <= 8'h00;
      tick_100m_o <= 1'b0;
      tick_20m_o  <= 1'b0;
      tick_100k_o <= 1'b0;
    end else begin
      tick_100m_o <= m_if.tick;
      tick_20m_o  <= 1'b0;
      tick_100k_o <= 1'b0;
      if (m_if.tick) begin
        if (div20_r == DIV20_LAST) begin
          div20_r    <= 3'h0;
          tick_20m_o <= 1'b1;
        end else begin
          div20_r <= div20_r + 3'h1;
        end
      end
      if (tick_20m_o) begin
        if (div100k_r == DIV100K_LAST) begin
          div100k_r   <= 8'h00;
          tick_100k_o <= 1'b1;
        end else begin
          div100k_r <= div100k_r + 8'h01;
        end
      end
    end
  end

  // Each counter picks its own source; analog timing takes the shared enables directly.
  for (genvar c = 0; c < NUM_CTR; c++) begin : g_ctr
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        ctr_tick_o[c] <= 1'b0;
      end else begin
        ctr_tick_o[c] <= ctr_tb_sel_i[c] ? tick_100k_o : tick_20m_o;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Reference export and status
  // ---------------------------------------------------------------------------
  // Export uses the oscillator-derived square wave so it never depends on the loop.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ref10_o         <= 1'b0;
      sync_bus_o      <= 8'h00;
      sync_bus_oe_n_o <= 8'hff;
      pft_o           <= 16'h0000;
      pft_oe_n_o      <= 16'hffff;
    end else begin
      if (r_if.tick) begin
        ref10_o <= !ref10_o;
      end
      sync_bus_o      <= {8{ref10_o}};
      sync_bus_oe_n_o <= USB_VARIANT ? 8'hff : ~exp_sync_en_i;
      pft_o           <= {16{ref10_o}};
      pft_oe_n_o      <= ~exp_pft_en_i;
    end
  end

  assign pll_on_o      = pll_on_r;
  assign ref_sel_o     = ref_sel_r;
  assign cfg_pending_o = pending_r;
  assign pll_locked_o  = locked_r;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  a_master_spacing: assert property (tick_100m_o |=> !tick_100m_o)
    else $error("Master enable fired on two cycles in a row.");
  a_div20_tick: assert property (m_if.tick && div20_r == DIV20_LAST |=> tick_20m_o)
    else $error("20 MHz enable missed its fifth master tick.");
  a_div100k_tick: assert property (tick_20m_o && div100k_r == DIV100K_LAST |=> tick_100k_o)
    else $error("100 kHz enable missed its divide count.");
  a_ctr_source: assert property (ctr_tb_sel_i[0] && tick_100k_o |=> ctr_tick_o[0])
    else $error("Counter did not follow the 100 kHz source.");
  a_ref_realign: assert property (pll_on_r && ref_rise |=> ##1 !tick_100m_o)
    else $error("Reference edge did not realign the master phase.");
  a_cfg_hold: assert property (tasks_busy_i |=> $stable(pll_on_r) && $stable(ref_sel_r))
    else $error("Loop configuration changed while a task ran.");
  a_ref10_toggle: assert property (r_if.tick |=> ref10_o != $past(ref10_o))
    else $error("10 MHz reference did not toggle.");
  a_export_drive: assert property (exp_pft_en_i[0] |=> !pft_oe_n_o[0] && pft_o[0] == $past(ref10_o))
    else $error("Terminal export did not drive the 10 MHz reference.");
  a_usb_no_sync: assert property (USB_VARIANT |-> sync_bus_oe_n_o == 8'hff && ref_sel_r >= SEL_PFT_BASE)
    else $error("USB build touched the shared sync bus.");
  a_lock_drop: assert property (!pll_on_r |=> !locked_r)
    else $error("Lock shown with the loop off.");

  c_locked:  cover property ($rose(locked_r));
  c_tick100k: cover property (tick_100k_o);
  c_pending: cover property (pending_r ##1 !tasks_busy_i ##1 !pending_r);

endmodule : tbr_timebase

// file: src/tbr_pkg.sv
// Constants shared by the timebase and reference clock routing block.
// Assumes a single 250 MHz system clock; every slower rate but the 10 MHz square wave is an enable pulse.
package tbr_pkg;

  // ---------------------------------------------------------------------------
  // Rates and dividers
  // ---------------------------------------------------------------------------
  localparam int CLK_MHZ    = 250;  // System clock rate.
  localparam int MASTER_MHZ = 100;  // Master timebase rate.
  localparam int REF10_MHZ  = 10;   // Exported reference clock rate.
  localparam int DIV_20M    = 5;    // 100 MHz to 20 MHz.
  localparam int DIV_100K   = 200;  // 20 MHz to 100 kHz.
  localparam logic [2:0] DIV20_LAST  = 3'(DIV_20M - 1);
  localparam logic [7:0] DIV100K_LAST = 8'(DIV_100K - 1);

  // Phase accumulator steps: a tick fires when the sum wraps past the modulus.
  localparam logic [7:0] ACC_MOD      = 8'(CLK_MHZ);
  localparam logic [7:0] MASTER_INC   = 8'(MASTER_MHZ);
  localparam logic [7:0] REF10_INC    = 8'(2 * REF10_MHZ);  // Two toggles per period.

  // ---------------------------------------------------------------------------
  // Reference tracking
  // ---------------------------------------------------------------------------
  localparam int LOCK_TIMEOUT_NS = 1000;  // Longest gap between reference edges.
  localparam int LOCK_TO_CYC     = (LOCK_TIMEOUT_NS * CLK_MHZ) / 1000;
  localparam logic [9:0] LOCK_TO_LAST = 10'(LOCK_TO_CYC);
  localparam logic [2:0] LOCK_EDGES   = 3'h4;  // Edges in a row counted; lock sets on the next edge.

  // ---------------------------------------------------------------------------
  // External reference selection codes
  // ---------------------------------------------------------------------------
  localparam int NUM_SYNC = 8;
  localparam int NUM_PFT  = 16;
  localparam int NUM_SRC  = 28;
  typedef logic [4:0] tbr_sel_type;
  localparam tbr_sel_type SEL_SYNC_BASE = 5'h00;  // Shared sync-bus lines 0..7.
  localparam tbr_sel_type SEL_PFT_BASE  = 5'h08;  // Function terminals 0..15.
  localparam tbr_sel_type SEL_BP100     = 5'h18;  // Backplane 100 MHz clock.
  localparam tbr_sel_type SEL_STAR      = 5'h19;  // Star trigger.
  localparam tbr_sel_type SEL_DSTAR_A   = 5'h1a;  // Differential star A.
  localparam tbr_sel_type SEL_DSTAR_B   = 5'h1b;  // Differential star B.
  localparam tbr_sel_type SEL_LIMIT     = 5'(NUM_SRC);

endpackage : tbr_pkg

// file: src/tbr_tick_if.sv
// Carrier between the timebase top and its phase accumulators.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface tbr_tick_if;
  logic phase_rst;  // Realign the accumulator phase to zero.
  logic tick;       // One-cycle enable at the generated rate.
  modport gen (input phase_rst, output tick);
  modport use_ (output phase_rst, input tick);
endinterface : tbr_tick_if

// file: src/tbr_phase_acc.sv
// Fractional rate generator: one-cycle tick at INC/MOD of the system clock.
// Assumes INC is below MOD; the tick comes straight from a flip-flop.
`timescale 1ns/1ps
module tbr_phase_acc #(
  parameter logic [7:0] INC = 8'h64,  // Step per clock.
  parameter logic [7:0] MOD = 8'hfa   // Wrap modulus.
) (
  input  wire logic  clk_sys_i,  // System clock.
  input  wire logic  arst_n_i,   // Asynchronous reset, active low.
  tbr_tick_if.gen    tk          // Phase realign in, tick out.
);

  logic [7:0] acc_r;
  logic [8:0] sum;

  assign sum = {1'b0, acc_r} + {1'b0, INC};

  // A realign clears both phase and any pending tick so the next tick lands a fixed time after it.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acc_r   <= 8'h00;
      tk.tick <= 1'b0;
    end else if (tk.phase_rst) begin
      acc_r   <= 8'h00;
      tk.tick <= 1'b0;
    end else if (sum >= {1'b0, MOD}) begin
      acc_r   <= 8'(sum - {1'b0, MOD});
      tk.tick <= 1'b1;
    end else begin
      acc_r   <= sum[7:0];
      tk.tick <= 1'b0;
    end
  end

endmodule : tbr_phase_acc

// file: bench/tbr_clk_partner.sv
// Model of an initiator device that drives a 10 MHz reference onto a shared line.
// Assumes the bench routes this one line to whichever reference pin is under test.
`timescale 1ns/1ps
module tbr_clk_partner (
  input  wire logic en_i,   // Initiator exporting its reference.
  output logic      line_o  // Shared line level.
);
  // ---------------------------------------------------------------------------
  // Reference source
  // ---------------------------------------------------------------------------
  // A free 10 MHz wave with an odd offset, so its edges never meet the bench clock.
  // A released line falls to its pull-down level rather than holding its last value.
  initial begin
    line_o = 1'b0;
    #1.3;
    forever begin
      #50;
      line_o = en_i ? ~line_o : 1'b0;
    end
  end
endmodule : tbr_clk_partner

// file: bench/tbr_timebase_tb.sv
// Self-checking bench for the timebase and reference clock routing block.
// Assumes one 250 MHz clock; a partner model stands in for the clock initiator.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("BAD %s exp %0h got %0h", nm, (ex), (got)); end end
module tbr_timebase_tb;
  import tbr_pkg::*;
  // ---------------------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------------------
  logic        clk_sys_i  = 1'b0;      // System clock.
  logic        arst_n_i   = 1'b0;      // Reset, active low.
  logic        pll_en     = 1'b0;      // Loop request.
  tbr_sel_type ref_sel    = 5'h00;     // Source request.
  logic        busy       = 1'b0;      // A task is running.
  logic [3:0]  ctr_sel    = 4'h0;      // Counter source picks.
  logic [7:0]  exp_sync   = 8'h00;     // Export enables, sync bus.
  logic [15:0] exp_pft    = 16'h0000;  // Export enables, terminals.
  logic        partner_en = 1'b0;      // Initiator exporting.
  int          src_code   = 0;         // Pin the partner wave reaches.
  int          n_mismatch = 0;         // Mismatches seen.
  int          checked    = 0;         // Comparisons made.
  logic        wave;                   // Partner line level.
  logic [27:0] lines;                  // All selectable reference pins.
  logic        t100m, t20m, t100k, ref10, pll_on, pend, locked;
  logic [3:0]  ctr_tk;
  logic [7:0]  sb_o, sb_oe_n, usb_oe_n;
  logic [15:0] pft_o, pft_oe_n;
  tbr_sel_type sel_o, usb_sel;

  // Clock runs free at 250 MHz.
  initial begin
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  // Only the pin that matches the code under test carries the wave.
  assign lines = wave ? (28'h1 << src_code) : 28'h0;

  tbr_clk_partner partner_u (.en_i(partner_en), .line_o(wave));

  tbr_timebase #(.USB_VARIANT(1'b0), .NUM_CTR(4)) dut_u (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .pll_en_i(pll_en), .ref_sel_i(ref_sel), .tasks_busy_i(busy),
    .ctr_tb_sel_i(ctr_sel), .sync_bus_i(lines[7:0]), .pft_i(lines[23:8]), .bp100_i(lines[24]),
    .star_i(lines[25]), .dstar_a_i(lines[26]), .dstar_b_i(lines[27]), .exp_sync_en_i(exp_sync),
    .exp_pft_en_i(exp_pft), .tick_100m_o(t100m), .tick_20m_o(t20m), .tick_100k_o(t100k),
    .ctr_tick_o(ctr_tk), .ref10_o(ref10), .sync_bus_o(sb_o), .sync_bus_oe_n_o(sb_oe_n), .pft_o(pft_o),
    .pft_oe_n_o(pft_oe_n), .pll_on_o(pll_on), .ref_sel_o(sel_o), .cfg_pending_o(pend),
    .pll_locked_o(locked));

  // The USB build shares every input, counter rates included; only its sync-bus enables and applied source code are judged.
  tbr_timebase #(.USB_VARIANT(1'b1), .NUM_CTR(4)) dut_usb (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .pll_en_i(pll_en), .ref_sel_i(ref_sel), .tasks_busy_i(busy),
    .ctr_tb_sel_i(ctr_sel), .sync_bus_i(lines[7:0]), .pft_i(lines[23:8]), .bp100_i(lines[24]),
    .star_i(lines[25]), .dstar_a_i(lines[26]), .dstar_b_i(lines[27]), .exp_sync_en_i(exp_sync),
    .exp_pft_en_i(exp_pft), .tick_100m_o(), .tick_20m_o(), .tick_100k_o(), .ctr_tick_o(), .ref10_o(),
    .sync_bus_o(), .sync_bus_oe_n_o(usb_oe_n), .pft_o(), .pft_oe_n_o(), .pll_on_o(), .ref_sel_o(usb_sel),
    .cfg_pending_o(), .pll_locked_o());

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  // Outputs are quiet in reset and the oscillator path stays selected after it.
  task automatic t_reset();
    repeat (8) @(negedge clk_sys_i);
    `CHK("tick_100m_o", 1'b0, t100m)
    `CHK("sync_bus_oe_n_o", 8'hff, sb_oe_n)
    `CHK("pft_oe_n_o", 16'hffff, pft_oe_n)
    repeat (8) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    repeat (2) @(negedge clk_sys_i);
    `CHK("pll_on_o", 1'b0, pll_on)
    `CHK("ref_sel_o", 5'h00, sel_o)
    `CHK("pll_locked_o", 1'b0, locked)
    `CHK("usb ref_sel_o", SEL_PFT_BASE, usb_sel)
    $display("test reset done");
  endtask : t_reset

  // Counts over a window that holds whole periods of every rate.
  task automatic t_rates();
    int n100m, n20m, n100k, nref, nc0, nc1;
    logic prev;
    n100m = 0; n20m = 0; n100k = 0; nref = 0; nc0 = 0; nc1 = 0;
    @(posedge clk_sys_i);
    ctr_sel <= 4'b0101;
    repeat (4) @(negedge clk_sys_i);
    prev = ref10;
    for (int i = 0; i < 10000; i++) begin
      @(negedge clk_sys_i);
      n100m += int'(t100m === 1'b1);
      n20m += int'(t20m === 1'b1);
      n100k += int'(t100k === 1'b1);
      nc0 += int'(ctr_tk[0] === 1'b1);
      nc1 += int'(ctr_tk[1] === 1'b1);
      nref += int'(ref10 === 1'b1 && prev === 1'b0);
      prev = ref10;
    end
    `CHK("tick_100m_o count", 10000 * MASTER_MHZ / CLK_MHZ, n100m)
    `CHK("tick_20m_o count", 10000 * MASTER_MHZ / CLK_MHZ / DIV_20M, n20m)
    `CHK("tick_100k_o count", 10000 * MASTER_MHZ / CLK_MHZ / DIV_20M / DIV_100K, n100k)
    `CHK("ctr_tick_o 100k count", 10000 * MASTER_MHZ / CLK_MHZ / DIV_20M / DIV_100K, nc0)
    `CHK("ctr_tick_o 20m count", 10000 * MASTER_MHZ / CLK_MHZ / DIV_20M, nc1)
    `CHK("ref10_o rises", 10000 * REF10_MHZ / CLK_MHZ, nref)
    $display("test rates done");
  endtask : t_rates

  // Exported lines follow the reference one cycle late; the USB build never drives the sync bus.
  task automatic t_export();
    logic prev;
    @(posedge clk_sys_i);
    exp_sync <= 8'h81;
    exp_pft <= 16'h8001;
    repeat (2) @(negedge clk_sys_i);
    `CHK("sync_bus_oe_n_o", 8'h7e, sb_oe_n)
    `CHK("pft_oe_n_o", 16'h7ffe, pft_oe_n)
    `CHK("usb sync_bus_oe_n_o", 8'hff, usb_oe_n)
    prev = ref10;
    for (int i = 0; i < 60; i++) begin
      @(negedge clk_sys_i);
      `CHK("sync_bus_o", {prev, 6'h00, prev}, {sb_o[7], 6'h00, sb_o[0]})
      `CHK("pft_o", {prev, prev}, {pft_o[15], pft_o[0]})
      prev = ref10;
    end
    @(posedge clk_sys_i);
    exp_sync <= 8'h00;
    exp_pft <= 16'h0000;
    repeat (2) @(negedge clk_sys_i);
    `CHK("sync_bus_oe_n_o off", 8'hff, sb_oe_n)
    $display("test export done");
  endtask : t_export

  // A loop change is held off while busy, then applied; an unknown code is ignored.
  task automatic t_busy_hold();
    @(posedge clk_sys_i);
    busy <= 1'b1;
    pll_en <= 1'b1;
    ref_sel <= SEL_PFT_BASE;
    repeat (3) @(negedge clk_sys_i);
    `CHK("pll_on_o busy", 1'b0, pll_on)
    `CHK("cfg_pending_o", 1'b1, pend)
    @(posedge clk_sys_i);
    busy <= 1'b0;
    repeat (2) @(negedge clk_sys_i);
    `CHK("pll_on_o", 1'b1, pll_on)
    `CHK("ref_sel_o", SEL_PFT_BASE, sel_o)
    `CHK("cfg_pending_o idle", 1'b0, pend)
    @(posedge clk_sys_i);
    ref_sel <= SEL_LIMIT;
    repeat (2) @(negedge clk_sys_i);
    `CHK("ref_sel_o bad code", SEL_PFT_BASE, sel_o)
    $display("test busy done");
  endtask : t_busy_hold

  // Every source locks the loop to the partner wave, and loss of it is flagged.
  task automatic t_lock_all();
    int w;
    for (int c = 0; c < NUM_SRC; c++) begin
      @(posedge clk_sys_i);
      ref_sel <= tbr_sel_type'(c);
      src_code <= c;
      partner_en <= 1'b1;
      for (w = 0; w < 600 && locked !== 1'b1; w++) @(negedge clk_sys_i);
      `CHK("ref_sel_o", tbr_sel_type'(c), sel_o)
      `CHK("usb ref_sel_o", (c < NUM_SYNC) ? SEL_PFT_BASE : tbr_sel_type'(c), usb_sel)
      `CHK("pll_locked_o", 1'b1, locked)
      if (locked !== 1'b1) end_sim();
      @(posedge clk_sys_i);
      partner_en <= 1'b0;
      for (w = 0; w < 600 && locked !== 1'b0; w++) @(negedge clk_sys_i);
      `CHK("pll_locked_o lost", 1'b0, locked)
      if (locked !== 1'b0) end_sim();
    end
    $display("test lock done");
  endtask : t_lock_all

  // ---------------------------------------------------------------------------
  // Verdict
  // ---------------------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  // Main sequence.
  initial begin
    t_reset();
    t_rates();
    t_export();
    t_busy_hold();
    t_lock_all();
    end_sim();
  end
endmodule : tbr_timebase_tb
